// [core/irc_defines.svh]
`ifndef IRC_DEFINES_SVH
`define IRC_DEFINES_SVH
`define IRC_DEV_ADDR 7'h40
`define IRC_DIR_WRITE 1'h0
`define IRC_DIR_READ 1'h1
`define IRC_REG_PRESET1 8'h01
`define IRC_REG_PRESET2 8'h02
`define IRC_REG_MISC 8'h03
`define IRC_REG_FLAGS 8'h05
`define IRC_PRESET1_RST 8'h10
`define IRC_PRESET2_RST 8'h38
`define IRC_MISC_RST 8'h6B
`define IRC_FLAGS_RST 8'h00
`define IRC_UNMAPPED_DATA 8'h00
`define IRC_CODE_MASK 8'h7F
`define IRC_MISC_RW_MASK 8'h7B
`define IRC_MISC_RESET_BIT 7
`define IRC_MISC_DISCHARGE_BIT 3
`define IRC_PRESET2_PWM_BIT 7
`define IRC_FLAG_THERMAL_BIT 4
`define IRC_FLAG_PBAD_BIT 2
`define IRC_BITS_PER_BYTE 4'h8
`define IRC_CLK_KHZ 20000
`define IRC_SCL_KHZ 100
`define IRC_QUARTER_CYCLES (`IRC_CLK_KHZ / (`IRC_SCL_KHZ * 4))
`define IRC_STARTUP_DELAY_US 1000
`define IRC_STARTUP_CYCLES (`IRC_STARTUP_DELAY_US * `IRC_CLK_KHZ / 1000)
`define IRC_H_REGADDR 5'h00
`define IRC_H_WDATA 5'h04
`define IRC_H_CTRL 5'h08
`define IRC_H_STATUS 5'h0C
`define IRC_H_RDATA 5'h10
`define IRC_H_GO_BIT 0
`define IRC_H_READ_BIT 1
`define IRC_H_INIT_STEP 3'h7
`endif

// [core/irc_pkg.sv]
package irc_pkg;
    typedef enum logic [3:0] {
        DS_IDLE = 4'h0,
        DS_ADDR = 4'h1,
        DS_ADDR_ACK = 4'h3,
        DS_REG = 4'h2,
        DS_REG_ACK = 4'h6,
        DS_DATA = 4'h7,
        DS_DATA_ACK = 4'h5,
        DS_READ = 4'h4,
        DS_READ_ACK = 4'hC,
        DS_IGNORE = 4'hD
    } irc_dstate_t;
    typedef enum logic [2:0] {
        HS_IDLE = 3'h0,
        HS_START = 3'h1,
        HS_TX = 3'h3,
        HS_RX = 3'h2,
        HS_STOP = 3'h6
    } irc_hstate_t;
endpackage

// [core/irc_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface irc_if;
    logic scl_m_o;
    logic scl_m_oe_n;
    logic sda_m_o;
    logic sda_m_oe_n;
    logic sda_s_o;
    logic sda_s_oe_n;
    logic scl_i;
    logic sda_i;
    // wired-and with pull-up: a released line reads high
    assign scl_i = scl_m_oe_n | scl_m_o;
    assign sda_i = (sda_m_oe_n | sda_m_o) & (sda_s_oe_n | sda_s_o);
    modport host (output scl_m_o, output scl_m_oe_n, output sda_m_o, output sda_m_oe_n,
                  input sda_i);
    modport device (output sda_s_o, output sda_s_oe_n, input scl_i, input sda_i);
endinterface
`default_nettype wire

// [core/irc_device.sv]
// Added by the designer: the register device on the two-wire bus.
`timescale 1ns/1ns
`default_nettype none
`include "irc_defines.svh"
module irc_device #(
    parameter int STARTUP_CYCLES = `IRC_STARTUP_CYCLES
) (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic ce_i,
    irc_if.device bus,
    input wire logic supply_low_i,
    input wire logic supply_dead_i,
    input wire logic hw_enable_i,
    input wire logic thermal_trip_i,
    input wire logic power_bad_i,
    output logic [6:0] preset_one_code_o,
    output logic [6:0] preset_two_code_o,
    output logic preset_two_pwm_o,
    output logic [7:0] misc_config_o,
    output logic discharge_enable_o,
    output logic startup_busy_o
);
    import irc_pkg::*;

    logic [2:0] scl_sync_reg;
    logic [2:0] sda_sync_reg;
    logic scl_f_reg;
    logic sda_f_reg;
    logic scl_q_reg;
    logic sda_q_reg;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    irc_dstate_t state_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] tx_reg;
    logic [7:0] ptr_reg;
    logic [7:0] wdata_reg;
    logic rw_reg;
    logic master_ack_reg;
    logic sda_rel_reg;
    logic busy;
    logic commit;
    logic load_read;
    logic flags_read;
    logic soft_reset;
    logic reg_clear;
    logic [7:0] preset1_reg;
    logic [7:0] preset2_reg;
    logic [7:0] misc_reg;
    logic [7:0] flags_reg;
    logic [7:0] read_data;
    logic [7:0] flag_set;
    logic en_q_reg;
    logic en_fall;
    logic en_rise;
    logic hold_valid_reg;
    logic hold_value_reg;
    logic [19:0] delay_cnt_reg;

    // a level only counts once two late stages agree, filtering spikes
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            scl_sync_reg <= 3'h7;
            sda_sync_reg <= 3'h7;
            scl_f_reg <= 1'h1;
            sda_f_reg <= 1'h1;
            scl_q_reg <= 1'h1;
            sda_q_reg <= 1'h1;
        end else if (ce_i) begin
            scl_sync_reg <= {scl_sync_reg[1:0], bus.scl_i};
            sda_sync_reg <= {sda_sync_reg[1:0], bus.sda_i};
            if (scl_sync_reg[1] == scl_sync_reg[2]) begin
                scl_f_reg <= scl_sync_reg[2];
            end
            if (sda_sync_reg[1] == sda_sync_reg[2]) begin
                sda_f_reg <= sda_sync_reg[2];
            end
            scl_q_reg <= scl_f_reg;
            sda_q_reg <= sda_f_reg;
        end
    end

    assign scl_rise = scl_f_reg & ~scl_q_reg;
    assign scl_fall = ~scl_f_reg & scl_q_reg;
    assign start_seen = scl_f_reg & scl_q_reg & sda_q_reg & ~sda_f_reg;
    assign stop_seen = scl_f_reg & scl_q_reg & ~sda_q_reg & sda_f_reg;
    assign busy = delay_cnt_reg != 20'h00000;
    assign commit = scl_fall & (state_reg == DS_DATA_ACK);
    assign load_read = scl_fall & (((state_reg == DS_ADDR_ACK) & rw_reg)
                       | ((state_reg == DS_READ_ACK) & master_ack_reg));
    assign flags_read = load_read & (ptr_reg == `IRC_REG_FLAGS);
    assign soft_reset = commit & ~busy & (ptr_reg == `IRC_REG_MISC)
                        & wdata_reg[`IRC_MISC_RESET_BIT];
    assign en_fall = en_q_reg & ~hw_enable_i;
    assign en_rise = ~en_q_reg & hw_enable_i;
    assign reg_clear = supply_low_i | en_fall | soft_reset;

    // upper select bits must be zero, so a full-byte compare decodes
    always_comb begin
        case (ptr_reg)
            `IRC_REG_PRESET1: read_data = preset1_reg;
            `IRC_REG_PRESET2: read_data = preset2_reg;
            `IRC_REG_MISC: read_data = misc_reg;
            `IRC_REG_FLAGS: read_data = flags_reg;
            default: read_data = `IRC_UNMAPPED_DATA;
        endcase
    end

    always_comb begin
        flag_set = `IRC_FLAGS_RST;
        flag_set[`IRC_FLAG_THERMAL_BIT] = thermal_trip_i;
        flag_set[`IRC_FLAG_PBAD_BIT] = power_bad_i;
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            state_reg <= DS_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            ptr_reg <= 8'h00;
            wdata_reg <= 8'h00;
            rw_reg <= 1'h0;
            master_ack_reg <= 1'h0;
            sda_rel_reg <= 1'h1;
        end else if (ce_i) begin
            if (start_seen) begin
                state_reg <= DS_ADDR;
                bit_cnt_reg <= 4'h0;
                sda_rel_reg <= 1'h1;
            end else if (stop_seen) begin
                state_reg <= DS_IDLE;
                sda_rel_reg <= 1'h1;
            end else if (scl_rise) begin
                case (state_reg)
                    DS_ADDR, DS_REG, DS_DATA: begin
                        shift_reg <= {shift_reg[6:0], sda_f_reg};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                    DS_READ: bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    DS_READ_ACK: master_ack_reg <= ~sda_f_reg;
                    default: ;
                endcase
            end else if (scl_fall) begin
                case (state_reg)
                    DS_ADDR: begin
                        if (bit_cnt_reg == `IRC_BITS_PER_BYTE) begin
                            if (shift_reg[7:1] == `IRC_DEV_ADDR) begin
                                state_reg <= DS_ADDR_ACK;
                                rw_reg <= shift_reg[0];
                                sda_rel_reg <= 1'h0;
                            end else begin
                                state_reg <= DS_IGNORE;
                            end
                        end
                    end
                    DS_ADDR_ACK: begin
                        bit_cnt_reg <= 4'h0;
                        if (rw_reg == `IRC_DIR_READ) begin
                            state_reg <= DS_READ;
                            tx_reg <= read_data;
                            sda_rel_reg <= read_data[7];
                        end else begin
                            state_reg <= DS_REG;
                            sda_rel_reg <= 1'h1;
                        end
                    end
                    DS_REG: begin
                        if (bit_cnt_reg == `IRC_BITS_PER_BYTE) begin
                            ptr_reg <= shift_reg;
                            sda_rel_reg <= 1'h0;
                            state_reg <= DS_REG_ACK;
                        end
                    end
                    DS_DATA: begin
                        if (bit_cnt_reg == `IRC_BITS_PER_BYTE) begin
                            wdata_reg <= shift_reg;
                            sda_rel_reg <= 1'h0;
                            state_reg <= DS_DATA_ACK;
                        end
                    end
                    DS_REG_ACK, DS_DATA_ACK: begin
                        // further data bytes rewrite the same register
                        sda_rel_reg <= 1'h1;
                        bit_cnt_reg <= 4'h0;
                        state_reg <= DS_DATA;
                    end
                    DS_READ: begin
                        if (bit_cnt_reg == `IRC_BITS_PER_BYTE) begin
                            sda_rel_reg <= 1'h1;
                            state_reg <= DS_READ_ACK;
                        end else begin
                            tx_reg <= {tx_reg[6:0], 1'h0};
                            sda_rel_reg <= tx_reg[6];
                        end
                    end
                    DS_READ_ACK: begin
                        if (master_ack_reg) begin
                            tx_reg <= read_data;
                            sda_rel_reg <= read_data[7];
                            bit_cnt_reg <= 4'h0;
                            state_reg <= DS_READ;
                        end else begin
                            state_reg <= DS_IGNORE;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // writes during the start-up delay are acked but dropped
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            preset1_reg <= `IRC_PRESET1_RST;
            preset2_reg <= `IRC_PRESET2_RST;
            misc_reg <= `IRC_MISC_RST;
        end else if (ce_i) begin
            if (reg_clear) begin
                preset1_reg <= `IRC_PRESET1_RST;
                preset2_reg <= `IRC_PRESET2_RST;
                misc_reg <= `IRC_MISC_RST;
            end else if (commit & ~busy) begin
                case (ptr_reg)
                    `IRC_REG_PRESET1: preset1_reg <= wdata_reg & `IRC_CODE_MASK;
                    `IRC_REG_PRESET2: preset2_reg <= wdata_reg;
                    `IRC_REG_MISC: misc_reg <= wdata_reg & `IRC_MISC_RW_MASK;
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            flags_reg <= `IRC_FLAGS_RST;
        end else if (ce_i) begin
            if (reg_clear) begin
                flags_reg <= `IRC_FLAGS_RST;
            end else if (flags_read) begin
                flags_reg <= flag_set;
            end else begin
                flags_reg <= flags_reg | flag_set;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            en_q_reg <= 1'h0;
            hold_valid_reg <= 1'h0;
            hold_value_reg <= 1'h0;
        end else if (ce_i) begin
            en_q_reg <= hw_enable_i;
            if (en_fall) begin
                hold_valid_reg <= 1'h1;
                hold_value_reg <= misc_reg[`IRC_MISC_DISCHARGE_BIT];
            end else if (en_rise | supply_dead_i) begin
                hold_valid_reg <= 1'h0;
            end
        end
    end

    // delay only runs while enabled and the supply is good
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            delay_cnt_reg <= 20'(STARTUP_CYCLES);
        end else if (ce_i) begin
            if (supply_low_i | en_rise | soft_reset) begin
                delay_cnt_reg <= 20'(STARTUP_CYCLES);
            end else if (busy & hw_enable_i) begin
                delay_cnt_reg <= delay_cnt_reg - 20'h00001;
            end
        end
    end

    assign bus.sda_s_o = 1'h0;
    assign bus.sda_s_oe_n = sda_rel_reg;
    assign preset_one_code_o = preset1_reg[6:0];
    assign preset_two_code_o = preset2_reg[6:0];
    assign preset_two_pwm_o = preset2_reg[`IRC_PRESET2_PWM_BIT];
    assign misc_config_o = misc_reg;
    assign discharge_enable_o = hold_valid_reg ? hold_value_reg
                                : misc_reg[`IRC_MISC_DISCHARGE_BIT];
    assign startup_busy_o = busy;
endmodule
`default_nettype wire

// [core/irc_host.sv]
`timescale 1ns/1ns
`default_nettype none
`include "irc_defines.svh"
module irc_host (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic ce_i,
    irc_if.host bus,
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o
);
    import irc_pkg::*;

    irc_hstate_t state_reg;
    logic [2:0] sda_sync_reg;
    logic sda_f_reg;
    logic [15:0] qcnt_reg;
    logic [1:0] quarter_reg;
    logic [3:0] bit_reg;
    logic [2:0] step_reg;
    logic [2:0] step_next;
    logic rd_reg, nack_reg, done_reg, resp_reg;
    logic scl_rel_reg, sda_rel_reg, sda_next;
    logic tick, prim_end, wr_acc, rd_acc, go, is_bit;
    logic [7:0] regaddr_reg, wdata_reg, tx_reg, rx_reg, rdata_reg;
    logic [31:0] rdata_mux;

    function automatic irc_hstate_t prim(input logic [2:0] s, input logic rd);
        case (s)
            3'h0: prim = HS_START;
            3'h1, 3'h2: prim = HS_TX;
            3'h3: prim = rd ? HS_START : HS_TX;
            3'h4: prim = rd ? HS_TX : HS_STOP;
            3'h5: prim = HS_RX;
            default: prim = HS_STOP;
        endcase
    endfunction

    function automatic logic [7:0] tx_byte(input logic [2:0] s, input logic [7:0] ra,
                                           input logic [7:0] wd);
        case (s)
            3'h1: tx_byte = {`IRC_DEV_ADDR, `IRC_DIR_WRITE};
            3'h2: tx_byte = ra;
            3'h3: tx_byte = wd;
            default: tx_byte = {`IRC_DEV_ADDR, `IRC_DIR_READ};
        endcase
    endfunction

    // one wait state per access, so read data comes from a flop
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~resp_reg;
    assign wr_acc = avs_write_i & resp_reg & avs_byteenable_i[0];
    assign rd_acc = avs_read_i & resp_reg;
    assign go = wr_acc & (avs_address_i == `IRC_H_CTRL)
                & avs_writedata_i[`IRC_H_GO_BIT] & (state_reg == HS_IDLE);
    assign tick = qcnt_reg == 16'(`IRC_QUARTER_CYCLES - 1);
    assign is_bit = (state_reg == HS_TX) | (state_reg == HS_RX);
    assign prim_end = tick & (quarter_reg == 2'h3) & (~is_bit | (bit_reg == `IRC_BITS_PER_BYTE));
    // a refused byte skips ahead to the closing STOP
    assign step_next = ((state_reg == HS_TX) & nack_reg) ? (rd_reg ? 3'h6 : 3'h4)
                       : step_reg + 3'h1;

    always_comb begin
        case (avs_address_i)
            `IRC_H_REGADDR: rdata_mux = {24'h000000, regaddr_reg};
            `IRC_H_WDATA: rdata_mux = {24'h000000, wdata_reg};
            `IRC_H_CTRL: rdata_mux = {30'h00000000, rd_reg, 1'h0};
            `IRC_H_STATUS: rdata_mux = {29'h00000000, done_reg, nack_reg,
                                        state_reg != HS_IDLE};
            `IRC_H_RDATA: rdata_mux = {24'h000000, rdata_reg};
            default: rdata_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            resp_reg <= 1'h0;
            avs_readdata_o <= 32'h00000000;
            regaddr_reg <= 8'h00;
            wdata_reg <= 8'h00;
        end else if (ce_i) begin
            resp_reg <= (avs_read_i | avs_write_i) & ~resp_reg;
            avs_readdata_o <= rdata_mux;
            if (wr_acc & (avs_address_i == `IRC_H_REGADDR)) begin
                regaddr_reg <= avs_writedata_i[7:0];
            end
            if (wr_acc & (avs_address_i == `IRC_H_WDATA)) begin
                wdata_reg <= avs_writedata_i[7:0];
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            sda_sync_reg <= 3'h7;
            sda_f_reg <= 1'h1;
        end else if (ce_i) begin
            sda_sync_reg <= {sda_sync_reg[1:0], bus.sda_i};
            if (sda_sync_reg[1] == sda_sync_reg[2]) begin
                sda_f_reg <= sda_sync_reg[2];
            end
        end
    end

    // reset starts with a lone STOP so the slave leaves any stale state
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            state_reg <= HS_STOP;
            step_reg <= `IRC_H_INIT_STEP;
            qcnt_reg <= 16'h0000;
            quarter_reg <= 2'h0;
            bit_reg <= 4'h0;
            rd_reg <= 1'h0;
            nack_reg <= 1'h0;
            done_reg <= 1'h0;
            tx_reg <= 8'h00;
            rx_reg <= 8'h00;
            rdata_reg <= 8'h00;
        end else if (ce_i) begin
            if (rd_acc & (avs_address_i == `IRC_H_STATUS)) begin
                done_reg <= 1'h0;
            end
            if (state_reg == HS_IDLE) begin
                qcnt_reg <= 16'h0000;
                quarter_reg <= 2'h0;
                bit_reg <= 4'h0;
                if (go) begin
                    rd_reg <= avs_writedata_i[`IRC_H_READ_BIT];
                    nack_reg <= 1'h0;
                    step_reg <= 3'h0;
                    state_reg <= HS_START;
                end
            end else begin
                qcnt_reg <= tick ? 16'h0000 : qcnt_reg + 16'h0001;
                if (tick) begin
                    quarter_reg <= quarter_reg + 2'h1;
                end
                if (tick & (quarter_reg == 2'h2) & (state_reg == HS_TX)
                    & (bit_reg == `IRC_BITS_PER_BYTE)) begin
                    nack_reg <= sda_f_reg;
                end
                if (tick & (quarter_reg == 2'h2) & (state_reg == HS_RX)
                    & (bit_reg != `IRC_BITS_PER_BYTE)) begin
                    rx_reg <= {rx_reg[6:0], sda_f_reg};
                end
                if (tick & (quarter_reg == 2'h3) & is_bit) begin
                    bit_reg <= bit_reg + 4'h1;
                    tx_reg <= {tx_reg[6:0], 1'h1};
                end
                if (prim_end) begin
                    bit_reg <= 4'h0;
                    if (state_reg == HS_RX) begin
                        rdata_reg <= rx_reg;
                    end
                    if (state_reg == HS_STOP) begin
                        state_reg <= HS_IDLE;
                        if (step_reg != `IRC_H_INIT_STEP) begin
                            done_reg <= 1'h1; // set wins over the read clear
                        end
                    end else begin
                        step_reg <= step_next;
                        state_reg <= prim(step_next, rd_reg);
                        tx_reg <= tx_byte(step_next, regaddr_reg, wdata_reg);
                    end
                end
            end
        end
    end

    // SCL always falls a quarter before SDA may move, so no false START/STOP
    always_comb begin
        if (quarter_reg == 2'h0) begin
            sda_next = sda_rel_reg;
        end else begin
            case (state_reg)
                HS_START: sda_next = quarter_reg != 2'h3;
                HS_STOP: sda_next = quarter_reg == 2'h3;
                HS_TX: sda_next = (bit_reg == `IRC_BITS_PER_BYTE) | tx_reg[7];
                HS_RX: sda_next = 1'h1;
                default: sda_next = 1'h1;
            endcase
        end
    end

    // fixed 100 kHz framing only, never high-speed mode
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            scl_rel_reg <= 1'h1;
            sda_rel_reg <= 1'h1;
        end else if (ce_i) begin
            scl_rel_reg <= (state_reg == HS_IDLE) | quarter_reg[1];
            sda_rel_reg <= sda_next;
        end
    end

    assign bus.scl_m_o = 1'h0;
    assign bus.scl_m_oe_n = scl_rel_reg;
    assign bus.sda_m_o = 1'h0;
    assign bus.sda_m_oe_n = sda_rel_reg;
endmodule
`default_nettype wire

// [tb/irc_monitor.sv]
`timescale 1ns/1ns
`default_nettype none
module irc_monitor (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic scl_m_oe_n,
    input wire logic sda_s_o,
    input wire logic sda_s_oe_n,
    input wire logic scl_i,
    input wire logic sda_i
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);
    sequence s_start; scl_i && $past(scl_i) && $fell(sda_i); endsequence
    sequence s_stop; scl_i && $past(scl_i) && $rose(sda_i); endsequence
    a_dev_open: assert property ($rose(scl_i) && !sda_s_oe_n
        |-> (!(sda_s_oe_n | sda_s_o)) [*8]) else $error("bit dropped");
    a_stop_boot: assert property ($fell(reset_i) |-> ##[1:400] s_stop) else $error("no stop");
    a_start_quiet: assert property (s_start |=> sda_s_oe_n [*8]) else $error("early sda");
    a_stop_free: assert property (s_stop |=> sda_s_oe_n [*8]) else $error("late sda");
    a_ack_low: assert property ($fell(sda_s_oe_n) |-> !scl_i) else $error("ack edge");
    a_ack_hold: assert property ($fell(sda_s_oe_n) |-> !sda_s_oe_n [*8]) else $error("ack");
    a_high_stable: assert property (scl_i && $past(scl_i) |-> $stable(sda_s_oe_n))
        else $error("sda moved");
    a_scl_high: assert property ($rose(scl_m_oe_n) |-> scl_m_oe_n [*8]) else $error("scl");
endmodule
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic clock_i = 1'h0, reset_i = 1'h1, sup_low = 1'h0, hw_en = 1'h1, ev = 1'h0;
    logic rd = 1'h0, wr = 1'h0, sup_dead = 1'h0, wreq, pwm, dis, bsy;
    logic [4:0] adr = 5'h00;
    logic [7:0] wdat = 8'h00, misc, q;
    logic [31:0] rdat;
    logic [6:0] p1, p2;
    int miscompares = 0, cmp_count = 0;
    irc_if bus ();
    irc_device #(.STARTUP_CYCLES(20)) i_irc_device (.clock_i, .reset_i, .ce_i(1'h1),
        .bus(bus.device), .supply_low_i(sup_low), .supply_dead_i(sup_dead), .hw_enable_i(hw_en),
        .thermal_trip_i(ev), .power_bad_i(ev), .preset_one_code_o(p1), .preset_two_code_o(p2),
        .preset_two_pwm_o(pwm), .misc_config_o(misc), .discharge_enable_o(dis),
        .startup_busy_o(bsy));
    irc_host i_irc_host (.clock_i, .reset_i, .ce_i(1'h1), .bus(bus.host), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i({24'h0, wdat}), .avs_byteenable_i(4'h1),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wreq));
    irc_monitor i_irc_monitor (.clock_i, .reset_i, .scl_m_oe_n(bus.scl_m_oe_n),
        .sda_s_o(bus.sda_s_o), .sda_s_oe_n(bus.sda_s_oe_n), .scl_i(bus.scl_i), .sda_i(bus.sda_i));
    always #25 clock_i = ~clock_i;
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        miscompares += (got !== exp);
        if (got !== exp) $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    endtask
    task av(input logic w, input logic [4:0] a, input logic [7:0] d);
        @(posedge clock_i) {wr, rd, adr, wdat} <= {w, !w, a, d};
        do @(posedge clock_i); while (wreq !== 1'h0);
        q = rdat[7:0];
        {wr, rd} <= 2'h0;
    endtask
    // busy gate first: a go during the boot stop is dropped
    task xfer(input logic r, input logic [7:0] ra, input logic [7:0] d);
        av(1'h1, 5'h00, ra);
        av(1'h1, 5'h04, d);
        do av(1'h0, 5'h0C, 8'h00); while (q[0] !== 1'h0);
        av(1'h1, 5'h08, {6'h00, r, 1'h1});
        do av(1'h0, 5'h0C, 8'h00); while (q[2] !== 1'h1);
        chk(q[1], 1'h0);
        av(1'h0, 5'h10, 8'h00);
    endtask
    task t_defaults;
        chk({p1, pwm, p2, misc}, {7'h10, 1'h0, 7'h38, 8'h6B});
        xfer(1'h1, 8'h0D, 8'h00);
        chk(q, 8'h00);
        @(posedge clock_i) ev <= 1'h1;
        @(posedge clock_i) ev <= 1'h0;
        xfer(1'h1, 8'h05, 8'h00);
        chk(q, 8'h14);
        xfer(1'h1, 8'h05, 8'h00);
        chk(q, 8'h00);
        $display("defaults done");
    endtask
    task t_write;
        xfer(1'h0, 8'h01, 8'hFF);
        xfer(1'h0, 8'h02, 8'hB5);
        chk({p1, pwm, p2}, {7'h7F, 1'h1, 7'h35});
        xfer(1'h1, 8'h02, 8'h00);
        chk(q, 8'hB5);
        xfer(1'h0, 8'h03, 8'h80);
        chk({p1, pwm, p2, misc}, {7'h10, 1'h0, 7'h38, 8'h6B});
        $display("write done");
    endtask
    task t_power;
        xfer(1'h0, 8'h01, 8'h22);
        @(posedge clock_i) sup_low <= 1'h1;
        @(posedge clock_i) sup_low <= 1'h0;
        @(negedge clock_i) chk(p1, 7'h10);
        xfer(1'h0, 8'h03, 8'h63);
        @(posedge clock_i) hw_en <= 1'h0;
        repeat (3) @(negedge clock_i);
        chk({misc, dis}, {8'h6B, 1'h0});
        @(posedge clock_i) hw_en <= 1'h1;
        repeat (3) @(negedge clock_i);
        chk(dis, 1'h1);
        chk(bsy, 1'h1);
        xfer(1'h0, 8'h03, 8'h63);
        @(posedge clock_i) hw_en <= 1'h0;
        @(posedge clock_i) sup_dead <= 1'h1;
        @(posedge clock_i) sup_dead <= 1'h0;
        repeat (2) @(negedge clock_i);
        chk(dis, 1'h1);
        @(posedge clock_i) hw_en <= 1'h1;
        $display("power done");
    endtask
    task final_report;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clock_i);
        reset_i <= 1'h0;
        t_defaults;
        t_write;
        t_power;
        final_report;
    end
    initial begin
        repeat (95000) @(posedge clock_i);
        miscompares++;
        final_report;
    end
endmodule
`default_nettype wire
